// ==== logic/fbs_sequencer.sv ====
// Mode sequencer and fault logic of a current-mode flyback controller.
// Assumes comparator outputs are synchronous levels; rst is supply lockout.
`timescale 1ns/1ps
module fbs_sequencer
	import fbs_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                variant_fast,
	input  wire logic                brown_in,
	input  wire logic                supply_below_hold,
	input  wire logic                supply_above_hold,
	input  wire logic                fb_above_foldback_entry,
	input  wire logic                fb_above_foldback_depart,
	input  wire logic                fb_above_skip_entry,
	input  wire logic                fb_above_skip_depart,
	input  wire logic [7:0]          feedback_level,
	input  wire logic                pwm_comp_trip,
	input  wire logic                cs_above_slow_limit,
	input  wire logic                cs_above_fast_limit,
	input  wire logic                cs_above_short_level,
	input  wire logic                line_high,
	input  wire logic                supply_above_ovp,
	input  wire logic                demag_above_ovp,
	input  wire logic                demag_below_pull_low,
	input  wire logic                over_temp,
	input  wire logic [NFAULT-1:0]   latch_select,
	output logic                     gate_drive,
	output logic                     hv_charge_enable,
	output logic                     cs_open_pullup_enable,
	output logic [ILIM_W-1:0]        peak_limit,
	output logic [PER_W-1:0]         switch_period,
	output logic                     foldback_active,
	output logic                     skip_active,
	output logic [NFAULT-1:0]        fault_status,
	output logic                     thermal_stop
);
	fbs_state_t state;
	fbs_state_t next_state;
	logic [PER_W-1:0]  period_cnt;
	logic [PER_W-1:0]  next_period_cnt;
	logic [PER_W-1:0]  period;
	logic [PER_W-1:0]  next_period;
	logic [19:0]       ss_cnt;
	logic [19:0]       next_ss_cnt;
	logic [ILIM_W-1:0] limit;
	logic [ILIM_W-1:0] next_limit;
	logic              drive;
	logic              next_drive;
	logic              charge;
	logic              next_charge;
	logic              fold;
	logic              next_fold;
	logic [12:0]       ovp_cnt;
	logic [12:0]       next_ovp_cnt;
	logic [7:0]        dmag_cnt;
	logic [7:0]        next_dmag_cnt;
	logic              dmag_ok_hi;
	logic              next_dmag_ok_hi;
	logic              dmag_ok_lo;
	logic              next_dmag_ok_lo;
	logic              cyc_slow;
	logic              next_cyc_slow;
	logic              cyc_fast;
	logic              next_cyc_fast;
	logic [12:0]       olp_cnt;
	logic [12:0]       next_olp_cnt;
	logic [NFAULT-1:0] faults;
	logic [NFAULT-1:0] next_faults;
	logic              hot;
	logic              next_hot;
	logic              css_bad;
	logic              next_css_bad;
	logic              cycle_end;
	logic              in_tmin;
	logic [PER_W-1:0]  tmin;
	logic [PER_W-1:0]  max_on;
	logic [NFAULT-1:0] run_trip;
	logic [NFAULT-1:0] run_bad;
	logic [RUN_W-1:0]  run_need [NFAULT];
	logic              run_clear;

	function automatic logic [PER_W-1:0] full_period(input logic fast);
		full_period = fast ? PER_W'(PER_HI) : PER_W'(PER_LO);
	endfunction

	// =====================================================================
	// Switching cycle timing.
	// =====================================================================
	assign cycle_end = (period_cnt >= period - 14'h0001);
	assign tmin      = line_high ? PER_W'(TMIN_HI_CYC) : PER_W'(TMIN_LO_CYC);
	assign in_tmin   = period_cnt < tmin;
	assign max_on    = PER_W'((32'(period) * MAXDUTY_PCT) / 100);

	always_comb begin
		next_period_cnt = cycle_end ? '0 : period_cnt + 14'h0001;
		next_fold       = fold;
		next_period     = period;
		if (cycle_end) begin
			if (!fb_above_foldback_entry) begin
				next_fold = 1'b1;
			end else begin
				next_fold = 1'b0;
			end
			if (!fb_above_foldback_depart) begin
				next_period = PER_W'(PER_MAX);
			end else if (!fb_above_foldback_entry) begin
				next_period = full_period(variant_fast)
					+ PER_W'(32'(8'hFF - feedback_level) * 40);
				if (next_period > PER_W'(PER_MAX)) begin
					next_period = PER_W'(PER_MAX);
				end
			end else begin
				next_period = full_period(variant_fast);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			period_cnt <= '0;
			period     <= PER_W'(PER_LO);
			fold       <= 1'b0;
		end else begin
			period_cnt <= next_period_cnt;
			period     <= next_period;
			fold       <= next_fold;
		end
	end

	// =====================================================================
	// Mode sequence, soft-start and pulse control.
	// =====================================================================
	always_comb begin
		next_state  = state;
		next_ss_cnt = ss_cnt;
		next_limit  = limit;
		next_drive  = 1'b0;
		next_charge = charge;
		if (supply_below_hold) begin
			next_charge = 1'b1;
		end else if (supply_above_hold) begin
			next_charge = 1'b0;
		end
		unique case (state)
			FBS_OFF: begin
				next_state = FBS_STANDBY;
			end
			FBS_STANDBY: begin
				next_limit = '0;
				if (brown_in && !hot) begin
					next_state  = FBS_SOFTSTART;
					next_ss_cnt = '0;
				end
			end
			FBS_SOFTSTART: begin
				next_ss_cnt = ss_cnt + 20'h0_0001;
				next_limit  = ILIM_W'(32'(ss_cnt) * 32'(ILIM_FULL) / SS_CYC);
				if (32'(ss_cnt) >= SS_CYC - 1) begin
					next_state = FBS_RUN;
					next_limit = ILIM_FULL;
				end
			end
			FBS_RUN: begin
				if (cycle_end && !fb_above_skip_entry) begin
					next_state = FBS_SKIP;
				end
			end
			FBS_SKIP: begin
				if (cycle_end && fb_above_skip_depart) begin
					next_state = FBS_RUN;
				end
			end
			FBS_FAULT: begin
				if (faults == '0 && !hot) begin
					next_state = FBS_STANDBY;
				end
			end
		endcase
		if (state != FBS_OFF && state != FBS_STANDBY && (faults != '0 || hot)) begin
			next_state = FBS_FAULT;
		end
		if ((next_state == FBS_SOFTSTART || next_state == FBS_RUN) && state != FBS_FAULT) begin
			if (period_cnt == '0 || cycle_end) begin
				next_drive = !cycle_end;
			end else if (drive) begin
				next_drive = in_tmin
					|| !(pwm_comp_trip || cs_above_slow_limit || cs_above_fast_limit);
				if (period_cnt >= max_on) begin
					next_drive = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state  <= FBS_OFF;
			ss_cnt <= '0;
			limit  <= '0;
			drive  <= 1'b0;
			charge <= 1'b1;
		end else begin
			state  <= next_state;
			ss_cnt <= next_ss_cnt;
			limit  <= next_limit;
			drive  <= next_drive;
			charge <= next_charge;
		end
	end

	// =====================================================================
	// Protection detectors.
	// =====================================================================
	always_comb begin
		next_ovp_cnt    = supply_above_ovp ? ovp_cnt + 13'h0001 : '0;
		if (32'(ovp_cnt) >= OVP_CYC) begin
			next_ovp_cnt = ovp_cnt;
		end
		next_dmag_cnt   = drive ? '0 : dmag_cnt;
		next_dmag_ok_hi = dmag_ok_hi;
		next_dmag_ok_lo = dmag_ok_lo;
		if (!drive && 32'(dmag_cnt) < DMAG_CYC) begin
			next_dmag_cnt = dmag_cnt + 8'h01;
		end
		if (!drive && 32'(dmag_cnt) == DMAG_CYC - 1) begin
			next_dmag_ok_hi = demag_above_ovp;
			next_dmag_ok_lo = demag_below_pull_low;
		end
		next_cyc_slow = cyc_slow | (drive & cs_above_slow_limit);
		next_cyc_fast = cyc_fast | (drive & cs_above_fast_limit);
		next_css_bad  = css_bad;
		if (drive && period_cnt == tmin) begin
			next_css_bad = !cs_above_short_level;
		end
		next_olp_cnt = olp_cnt;
		if (cycle_end) begin
			next_cyc_slow = 1'b0;
			next_cyc_fast = 1'b0;
			next_css_bad  = 1'b0;
			next_dmag_ok_hi = 1'b0;
			next_dmag_ok_lo = 1'b0;
			if (cyc_slow) begin
				if (olp_cnt < 13'(OLP_OSC_CYCLES)) begin
					next_olp_cnt = olp_cnt + 13'h0001;
				end
			end else begin
				next_olp_cnt = '0;
			end
		end
		// Auto-recovering faults clear in the fault state; a trip in the same cycle wins.
		next_faults = faults;
		if (state == FBS_FAULT) begin
			for (int i = 0; i < NFAULT; i++) begin
				if (!latch_select[i]) begin
					next_faults[i] = 1'b0;
				end
			end
			next_olp_cnt = '0;
		end
		next_faults[F_VOVP] = next_faults[F_VOVP] | (32'(ovp_cnt) >= OVP_CYC);
		next_faults[F_DMOV] = next_faults[F_DMOV] | run_trip[F_DMOV];
		next_faults[F_PULL] = next_faults[F_PULL] | run_trip[F_PULL];
		next_faults[F_OLP]  = next_faults[F_OLP] | (olp_cnt >= 13'(OLP_OSC_CYCLES));
		next_faults[F_RECT] = next_faults[F_RECT] | run_trip[F_RECT];
		next_faults[F_CSS]  = next_faults[F_CSS] | run_trip[F_CSS];
		next_hot = over_temp;
	end

	assign run_bad[F_VOVP] = 1'b0;
	assign run_bad[F_DMOV] = dmag_ok_hi;
	assign run_bad[F_PULL] = dmag_ok_lo;
	assign run_bad[F_OLP]  = 1'b0;
	assign run_bad[F_RECT] = cyc_fast;
	assign run_bad[F_CSS]  = css_bad;
	assign run_need[F_VOVP] = '0;
	assign run_need[F_DMOV] = RUN_W'(DMOV_RUN);
	assign run_need[F_PULL] = RUN_W'(PULL_RUN);
	assign run_need[F_OLP]  = '0;
	assign run_need[F_RECT] = RUN_W'(RECT_RUN);
	assign run_need[F_CSS]  = line_high ? RUN_W'(CSS_RUN_HI) : RUN_W'(CSS_RUN_LO);
	assign run_clear = (state == FBS_FAULT);

	for (genvar g = 0; g < NFAULT; g++) begin : g_run
		fbs_run_counter u_run (
			.ref_clk   (ref_clk),
			.rst       (rst),
			.clear     (run_clear),
			.cycle_end (cycle_end),
			.bad       (run_bad[g]),
			.need      (run_need[g]),
			.trip      (run_trip[g])
		);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ovp_cnt    <= '0;
			dmag_cnt   <= '0;
			dmag_ok_hi <= 1'b0;
			dmag_ok_lo <= 1'b0;
			cyc_slow   <= 1'b0;
			cyc_fast   <= 1'b0;
			css_bad    <= 1'b0;
			olp_cnt    <= '0;
			faults     <= '0;
			hot        <= 1'b0;
		end else begin
			ovp_cnt    <= next_ovp_cnt;
			dmag_cnt   <= next_dmag_cnt;
			dmag_ok_hi <= next_dmag_ok_hi;
			dmag_ok_lo <= next_dmag_ok_lo;
			cyc_slow   <= next_cyc_slow;
			cyc_fast   <= next_cyc_fast;
			css_bad    <= next_css_bad;
			olp_cnt    <= next_olp_cnt;
			faults     <= next_faults;
			hot        <= next_hot;
		end
	end

	// =====================================================================
	// Outputs.
	// =====================================================================
	assign gate_drive            = drive;
	assign hv_charge_enable      = charge && (state == FBS_STANDBY || state == FBS_SKIP
		|| state == FBS_OFF);
	assign cs_open_pullup_enable = 1'b1;
	assign peak_limit            = limit;
	assign switch_period         = period;
	assign foldback_active       = fold;
	assign skip_active           = (state == FBS_SKIP);
	assign fault_status          = faults;
	assign thermal_stop          = hot;
endmodule // fbs_sequencer

// ==== logic/fbs_pkg.sv ====
// Constants shared by the flyback mode and protection sequencer.
// Assumes a 200 MHz ref_clk; analogue comparators arrive as synchronous levels.
package fbs_pkg;
	// Clock and derived times.
	localparam int CLK_MHZ          = 200;
	localparam int FSW_HI_KHZ       = 130;
	localparam int FSW_LO_KHZ       = 65;
	localparam int FSW_MIN_KHZ      = 20;
	localparam int PER_HI           = CLK_MHZ * 1000 / FSW_HI_KHZ;
	localparam int PER_LO           = CLK_MHZ * 1000 / FSW_LO_KHZ;
	localparam int PER_MAX          = CLK_MHZ * 1000 / FSW_MIN_KHZ;
	localparam int PER_W            = 14;
	localparam int OVP_DEGLITCH_US  = 20;
	localparam int OVP_CYC          = OVP_DEGLITCH_US * CLK_MHZ;
	localparam int DMAG_DEGLITCH_US = 1;
	localparam int DMAG_CYC         = DMAG_DEGLITCH_US * CLK_MHZ;
	localparam int OLP_OSC_CYCLES   = 4096;
	localparam int SS_MS            = 4;
	localparam int SS_CYC           = SS_MS * 1000 * CLK_MHZ;
	localparam int TMIN_LO_NS       = 3000;
	localparam int TMIN_HI_NS       = 800;
	localparam int TMIN_LO_CYC      = TMIN_LO_NS * CLK_MHZ / 1000;
	localparam int TMIN_HI_CYC      = TMIN_HI_NS * CLK_MHZ / 1000;
	localparam int MAXDUTY_PCT      = 75;
	// Cycle counts for consecutive faults.
	localparam int DMOV_RUN         = 5;
	localparam int PULL_RUN         = 2;
	localparam int RECT_RUN         = 5;
	localparam int CSS_RUN_LO       = 5;
	localparam int CSS_RUN_HI       = 3;
	localparam int RUN_W            = 3;
	// Peak current limit code width and full-scale code.
	localparam int ILIM_W           = 8;
	localparam logic [ILIM_W-1:0] ILIM_FULL = 8'hFF;
	// Fault indices.
	localparam int F_VOVP  = 0;
	localparam int F_DMOV  = 1;
	localparam int F_PULL  = 2;
	localparam int F_OLP   = 3;
	localparam int F_RECT  = 4;
	localparam int F_CSS   = 5;
	localparam int NFAULT  = 6;
	typedef enum logic [2:0] {
		FBS_OFF, FBS_STANDBY, FBS_SOFTSTART, FBS_RUN, FBS_SKIP, FBS_FAULT
	} fbs_state_t;
endpackage

// ==== logic/fbs_run_counter.sv ====
// Consecutive-cycle fault counter, advanced once per switching cycle.
// Assumes cycle_end pulses once at the end of each switching cycle.
`timescale 1ns/1ps
module fbs_run_counter
	import fbs_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clear,
	input  wire logic             cycle_end,
	input  wire logic             bad,
	input  wire logic [RUN_W-1:0] need,
	output logic                  trip
);
	logic [RUN_W-1:0] count;
	logic [RUN_W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (cycle_end) begin
			if (!bad) begin
				next_count = '0;
			end else if (count < need) begin
				next_count = count + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign trip = (count >= need) && (need != '0);
endmodule // fbs_run_counter

// ==== sim/fbs_sequencer_properties.sv ====
// Concurrent checks on the ports of the flyback mode and protection sequencer.
// Assumes it is bound into fbs_sequencer and sees only that module's ports.
`timescale 1ns/1ps
module fbs_sequencer_properties
	import fbs_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              variant_fast,
	input wire logic              brown_in,
	input wire logic              fb_above_foldback_entry,
	input wire logic              fb_above_foldback_depart,
	input wire logic              fb_above_skip_depart,
	input wire logic              line_high,
	input wire logic              pwm_comp_trip,
	input wire logic              supply_above_ovp,
	input wire logic              over_temp,
	input wire logic              gate_drive,
	input wire logic              cs_open_pullup_enable,
	input wire logic [ILIM_W-1:0] peak_limit,
	input wire logic [PER_W-1:0]  switch_period,
	input wire logic              foldback_active,
	input wire logic              skip_active,
	input wire logic [NFAULT-1:0] fault_status,
	input wire logic              thermal_stop
);
	localparam int OVP_CHK = OVP_CYC + 2;
	localparam int OVP_LOW = OVP_CYC - 2;
	logic        seen_bi;
	logic        next_seen_bi;
	logic [15:0] ovp_cnt;
	logic [15:0] next_ovp_cnt;
	logic [15:0] on_cnt;
	logic [15:0] next_on_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Helper state: brown-in history, over-voltage run length and gate on-time length
	always_comb begin
		next_seen_bi = seen_bi | brown_in;
		next_ovp_cnt = supply_above_ovp ? ovp_cnt + 16'h0001 : 16'h0000;
		next_on_cnt  = gate_drive ? on_cnt + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			seen_bi <= 1'h0;
			ovp_cnt <= 16'h0000;
			on_cnt  <= 16'h0000;
		end else begin
			seen_bi <= next_seen_bi;
			ovp_cnt <= next_ovp_cnt;
			on_cnt  <= next_on_cnt;
		end
	end
	// ==========================================================
	// Properties
	// A trip ends the pulse only once the minimum on-time has run out.
	sequence s_on_trip;
		gate_drive && pwm_comp_trip
			&& 32'(on_cnt) >= (line_high ? TMIN_HI_CYC : TMIN_LO_CYC) - 1;
	endsequence
	property p_standby_quiet;
		!seen_bi |-> !gate_drive;
	endproperty
	property p_peak_ramp;
		peak_limit >= $past(peak_limit) || peak_limit == 8'h00;
	endproperty
	property p_full_rate;
		gate_drive && !foldback_active && fb_above_foldback_entry && $past(fb_above_foldback_entry)
			&& $stable(variant_fast) |-> switch_period == (variant_fast ? PER_HI : PER_LO);
	endproperty
	property p_fold_clamp;
		foldback_active && $changed(switch_period) && !$past(fb_above_foldback_depart)
			|-> switch_period == PER_MAX;
	endproperty
	property p_skip_quiet;
		skip_active && $past(skip_active) |-> !gate_drive;
	endproperty
	property p_skip_hold;
		skip_active && !fb_above_skip_depart && fault_status == 6'h00 && !over_temp
			&& !supply_above_ovp |=> skip_active;
	endproperty
	property p_trip_off;
		s_on_trip |-> ##[1:2] !gate_drive;
	endproperty
	property p_ovp_stop;
		ovp_cnt == OVP_CHK |-> fault_status[F_VOVP] && !gate_drive;
	endproperty
	property p_ovp_glitch;
		$rose(fault_status[F_VOVP]) |-> ovp_cnt >= OVP_LOW;
	endproperty
	property p_fault_quiet;
		(|fault_status) && $past(|fault_status) |-> !gate_drive;
	endproperty
	property p_hot_quiet;
		thermal_stop && $past(thermal_stop) |-> !gate_drive;
	endproperty
	property p_pullup;
		cs_open_pullup_enable;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet)
		else $error("gate driven before brown-in");
	a_peak_ramp: assert property (p_peak_ramp)
		else $error("peak limit stepped down");
	a_full_rate: assert property (p_full_rate)
		else $error("heavy load period wrong");
	a_fold_clamp: assert property (p_fold_clamp)
		else $error("foldback period not clamped");
	a_skip_quiet: assert property (p_skip_quiet)
		else $error("gate driven while skipping");
	a_skip_hold: assert property (p_skip_hold)
		else $error("skip left below depart level");
	a_trip_off: assert property (p_trip_off)
		else $error("gate stayed on after current trip");
	a_ovp_stop: assert property (p_ovp_stop)
		else $error("supply over-voltage not stopping pulses");
	a_ovp_glitch: assert property (p_ovp_glitch)
		else $error("supply over-voltage tripped before deglitch");
	a_fault_quiet: assert property (p_fault_quiet)
		else $error("gate driven with a fault set");
	a_hot_quiet: assert property (p_hot_quiet)
		else $error("gate driven while hot");
	a_pullup: assert property (p_pullup)
		else $error("sense pull-up off");
endmodule // fbs_sequencer_properties

// ==== sim/fbs_stage_model.sv ====
// Behavioural power stage and comparators facing the sequencer.
// Assumes stage_fault from the bench: 1 demag high, 2 demag low, 3 fast trip, 4 sense short.
`timescale 1ns/1ps
module fbs_stage_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       gate_drive,
	input  wire logic [7:0] peak_limit,
	input  wire logic [2:0] stage_fault,
	output logic            pwm_comp_trip,
	output logic            cs_above_slow_limit,
	output logic            cs_above_fast_limit,
	output logic            cs_above_short_level,
	output logic            demag_above_ovp,
	output logic            demag_below_pull_low
);
	logic [9:0] ramp;
	logic [9:0] next_ramp;
	// ==========================================================
	// Primary current ramp while the switch is on
	always_comb begin
		next_ramp = gate_drive ? ramp + 10'h001 : 10'h000;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ramp <= 10'h000;
		end else begin
			ramp <= next_ramp;
		end
	end
	assign pwm_comp_trip        = gate_drive && (ramp[9:2] >= peak_limit);
	assign cs_above_slow_limit  = gate_drive && (stage_fault == 3'h3);
	assign cs_above_fast_limit  = gate_drive && (stage_fault == 3'h3);
	assign cs_above_short_level = gate_drive && (ramp > 10'h014) && (stage_fault != 3'h4);
	assign demag_above_ovp      = !gate_drive && (stage_fault == 3'h1);
	assign demag_below_pull_low = !gate_drive && (stage_fault == 3'h2);
endmodule // fbs_stage_model

// ==== sim/fbs_sequencer_tb.sv ====
// Self-checking bench for the flyback sequencer with a power stage model.
// Assumes the stage model and the property checker are compiled alongside.
`timescale 1ns/1ps
module fbs_sequencer_tb;
	import fbs_pkg::*;
	logic              ref_clk, rst, variant_fast, brown_in, line_high, over_temp;
	logic              supply_below_hold, supply_above_hold, supply_above_ovp;
	logic              fb_above_foldback_entry, fb_above_foldback_depart;
	logic              fb_above_skip_entry, fb_above_skip_depart;
	logic [7:0]        feedback_level, peak_limit, p1;
	logic              pwm_comp_trip, cs_above_slow_limit, cs_above_fast_limit;
	logic              cs_above_short_level, demag_above_ovp, demag_below_pull_low;
	logic [NFAULT-1:0] latch_select, fault_status;
	logic              gate_drive, hv_charge_enable, cs_open_pullup_enable;
	logic              foldback_active, skip_active, thermal_stop;
	logic [PER_W-1:0]  switch_period;
	logic [2:0]        stage_fault;
	logic [NFAULT:0]   exp_q[$];
	int                num_errors, checked;
	fbs_sequencer u_fbs_sequencer (.ref_clk, .rst, .variant_fast, .brown_in,
		.supply_below_hold, .supply_above_hold, .fb_above_foldback_entry,
		.fb_above_foldback_depart, .fb_above_skip_entry, .fb_above_skip_depart,
		.feedback_level, .pwm_comp_trip, .cs_above_slow_limit, .cs_above_fast_limit,
		.cs_above_short_level, .line_high, .supply_above_ovp, .demag_above_ovp,
		.demag_below_pull_low, .over_temp, .latch_select, .gate_drive, .hv_charge_enable,
		.cs_open_pullup_enable, .peak_limit, .switch_period, .foldback_active,
		.skip_active, .fault_status, .thermal_stop);
	fbs_stage_model u_fbs_stage_model (.ref_clk, .rst, .gate_drive, .peak_limit,
		.stage_fault, .pwm_comp_trip, .cs_above_slow_limit, .cs_above_fast_limit,
		.cs_above_short_level, .demag_above_ovp, .demag_below_pull_low);
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_status(input logic [NFAULT:0] got, input logic [NFAULT:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: status %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic restart(input logic bi);
		@(posedge ref_clk);
		rst <= 1'h1;
		brown_in <= 1'h0;
		stage_fault <= 3'h0;
		supply_above_ovp <= 1'h0;
		over_temp <= 1'h0;
		variant_fast <= 1'($urandom);
		line_high <= 1'($urandom);
		latch_select <= NFAULT'($urandom);
		feedback_level <= 8'($urandom);
		tick(10);
		rst <= 1'h0;
		tick(2);
		brown_in <= bi;
	endtask
	task automatic fault_case(input int idx, input logic [2:0] mode, input logic supply_overvoltage_trip,
		input logic hot, input int lim);
		int n;
		restart(1'h1);
		tick(100);
		if (supply_overvoltage_trip) begin
			supply_above_ovp <= 1'h1;
			tick(OVP_CYC / 2);
			supply_above_ovp <= 1'h0;
			tick(4);
		end
		exp_q.push_back(hot ? 7'h40 : 7'(1 << idx));
		stage_fault <= mode;
		supply_above_ovp <= supply_overvoltage_trip;
		over_temp <= hot;
		n = 0;
		while ((|{thermal_stop, fault_status}) !== 1'h1 && n < lim) begin
			tick(1);
			n++;
		end
		if (n >= lim) chk_status(7'h00, exp_q.pop_front());
		stage_fault <= 3'h0;
		supply_above_ovp <= 1'h0;
		over_temp <= 1'h0;
		tick(300);
		@(negedge ref_clk);
		if (hot) begin
			chk_val(14'(thermal_stop), 14'h0000);
		end else begin
			chk_val(14'(fault_status[idx]), 14'(latch_select[idx]));
		end
	endtask
	// ==========================================================
	// Result watcher: each new trip is matched against the oldest note
	initial forever begin
		@(posedge ref_clk iff ((|{thermal_stop, fault_status}) === 1'h1));
		#1;
		if (exp_q.size() == 0) chk_status({thermal_stop, fault_status}, 7'h00);
		else chk_status({thermal_stop, fault_status}, exp_q.pop_front());
		wait ((|{thermal_stop, fault_status}) === 1'h0);
	end
	initial begin
		tick(95000);
		num_errors++;
		stop_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(71787));
		rst = 1'h1;
		{variant_fast, brown_in, line_high, over_temp, supply_above_ovp} = 5'h00;
		{supply_below_hold, supply_above_hold} = 2'h0;
		{fb_above_foldback_entry, fb_above_foldback_depart} = 2'h3;
		{fb_above_skip_entry, fb_above_skip_depart} = 2'h3;
		feedback_level = 8'hFF;
		latch_select = 6'h00;
		stage_fault = 3'h0;
		num_errors = 0;
		checked = 0;
		restart(1'h0);
		supply_above_hold <= 1'h1;
		tick(4);
		@(negedge ref_clk);
		chk_val(14'(hv_charge_enable), 14'h0000);
		tick(1);
		supply_above_hold <= 1'h0;
		supply_below_hold <= 1'h1;
		tick(4);
		@(negedge ref_clk);
		chk_val(14'(hv_charge_enable), 14'h0001);
		tick(1);
		supply_below_hold <= 1'h0;
		tick(200);
		brown_in <= 1'h1;
		tick(3200);
		p1 = peak_limit;
		tick(6400);
		@(negedge ref_clk);
		chk_val(14'(peak_limit > p1), 14'h0001);
		chk_val(switch_period, variant_fast ? 14'(PER_HI) : 14'(PER_LO));
		tick(1);
		{fb_above_foldback_entry, fb_above_foldback_depart} <= 2'h0;
		tick(PER_LO + 10);
		@(negedge ref_clk);
		chk_val(switch_period, 14'(PER_MAX));
		chk_val(14'(foldback_active), 14'h0001);
		tick(1);
		{fb_above_foldback_entry, fb_above_foldback_depart} <= 2'h3;
		fault_case(F_VOVP, 3'h0, 1'h1, 1'h0, OVP_CYC + 50);
		fault_case(F_DMOV, 3'h1, 1'h0, 1'h0, 8 * PER_LO);
		fault_case(F_PULL, 3'h2, 1'h0, 1'h0, 8 * PER_LO);
		fault_case(F_RECT, 3'h3, 1'h0, 1'h0, 8 * PER_LO);
		fault_case(F_CSS, 3'h4, 1'h0, 1'h0, 8 * PER_LO);
		fault_case(0, 3'h0, 1'h0, 1'h1, 50);
		stop_test();
	end
endmodule // fbs_sequencer_tb
bind fbs_sequencer fbs_sequencer_properties u_fbs_sequencer_properties (.ref_clk, .rst,
	.variant_fast, .brown_in, .line_high, .fb_above_foldback_entry, .fb_above_foldback_depart,
	.fb_above_skip_depart, .pwm_comp_trip, .supply_above_ovp, .over_temp, .gate_drive,
	.cs_open_pullup_enable, .peak_limit, .switch_period, .foldback_active, .skip_active,
	.fault_status, .thermal_stop);
